// file: design/sap_host_port.v
// Purpose: processor side port of an async serial adapter
// Assumes: REF_CLK 10 MHz oversamples the bus phase clock and 16x receive clock
// Notes: receiver fed by external 16x clock edges, bytes buffered in a fifo
`timescale 1ns/1ps
`include "sap_defs.vh"
module sap_host_port (
   input wire REF_CLK,
   input wire RST_N,
   input wire PHI2,
   input wire READ_NOT_WRITE,
   input wire SELECT_ACTIVE_HIGH,
   input wire SELECT_ACTIVE_LOW_N,
   input wire REG_SELECT_LOW,
   input wire REG_SELECT_HIGH,
   input wire [7:0] HOST_DATA_IN,
   output reg [7:0] HOST_DATA_OUT,
   output reg HOST_DATA_OE_N,
   output reg IRQ_OUT,
   output reg IRQ_OE_N,
   input wire RECEIVE_CLOCK_16X,
   input wire SERIAL_IN,
   input wire DSR_N,
   input wire DCD_N,
   output reg SERIAL_OUT,
   output reg DTR_N
);
   wire [7:0] din_s;
   wire [9:0] ctl_s;
   wire phi2_s = ctl_s[0];
   wire rw_s = ctl_s[1];
   wire cs_s = ctl_s[2] & ~ctl_s[3];
   wire [1:0] rs_s = {ctl_s[5], ctl_s[4]};
   wire rxc_s = ctl_s[6];
   wire rxd_s = ctl_s[7];
   wire dsr_s = ctl_s[8];
   wire dcd_s = ctl_s[9];

   sap_sync #(.W(8)) u_sync_data (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .d(HOST_DATA_IN),
      .q(din_s)
   );
   // resets to pin idle levels, so no false edge follows reset
   sap_sync #(.W(10), .RST_VAL(`SAP_SYNC_CTL_IDLE)) u_sync_ctl (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .d({DCD_N, DSR_N, SERIAL_IN, RECEIVE_CLOCK_16X, REG_SELECT_HIGH, REG_SELECT_LOW,
          SELECT_ACTIVE_LOW_N, SELECT_ACTIVE_HIGH, READ_NOT_WRITE, PHI2}),
      .q(ctl_s)
   );

   reg phi2_q;
   reg rxc_q;
   reg [7:0] cmd_q;
   reg [7:0] ctl_q;
   reg [7:0] tx_hold_q;
   reg tdre_q;
   reg [7:0] rx_hold_q;
   reg rdrf_q;
   reg ovr_q;
   reg frm_q;
   reg irq_q;
   reg dsr_q;
   reg dcd_q;
   reg rd_pend_q;
   reg [1:0] rd_rs_q;
   reg [1:0] rx_st_q;
   reg [3:0] rx_ph_q;
   reg [3:0] rx_bit_q;
   reg [7:0] rx_sh_q;
   reg [1:0] tx_st_q;
   reg [3:0] tx_ph_q;
   reg [3:0] tx_bit_q;
   reg [7:0] tx_sh_q;

   localparam RX_IDLE = 2'b00;
   localparam RX_START = 2'b01;
   localparam RX_DATA = 2'b10;
   localparam RX_STOP = 2'b11;
   localparam TX_IDLE = 2'b00;
   localparam TX_START = 2'b01;
   localparam TX_DATA = 2'b10;
   localparam TX_STOP = 2'b11;

   wire phi2_fall = phi2_q & ~phi2_s;
   wire phi2_rise = ~phi2_q & phi2_s;
   wire rxc_rise = ~rxc_q & rxc_s;
   wire wr_stb = phi2_fall & cs_s & ~rw_s;
   wire rd_stb = phi2_rise & cs_s & rw_s;
   wire soft_rst = wr_stb && (rs_s == `SAP_RS_STAT);
   wire rd_data_done = phi2_fall & rd_pend_q & (rd_rs_q == `SAP_RS_DATA);
   wire rd_stat_done = phi2_fall & rd_pend_q & (rd_rs_q == `SAP_RS_STAT);

   // fifo between receiver shifter and holding register
   wire [7:0] ff_out;
   wire ff_out_valid;
   wire ff_in_ready;
   wire rx_byte_done = (rx_st_q == RX_STOP) && rxc_rise && (rx_ph_q == `SAP_OVS);
   wire ff_in_valid = rx_byte_done & rxd_s;
   wire ff_pop = ff_out_valid & ~rdrf_q;

   sap_fifo #(.W(`SAP_FIFO_W), .D(`SAP_FIFO_D), .AW(`SAP_FIFO_AW)) u_fifo (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .clr(soft_rst),
      .in_data(rx_sh_q),
      .in_valid(ff_in_valid),
      .in_ready(ff_in_ready),
      .out_data(ff_out),
      .out_valid(ff_out_valid),
      .out_ready(~rdrf_q)
   );

   // parity never flagged, framing is fixed 8N1
   reg [7:0] status;
   always @* begin
      status = `SAP_BYTE_ZERO;
      status[`SAP_ST_IRQ] = irq_q;
      status[`SAP_ST_DSR] = dsr_s;
      status[`SAP_ST_DCD] = dcd_s;
      status[`SAP_ST_TDRE] = tdre_q;
      status[`SAP_ST_RDRF] = rdrf_q;
      status[`SAP_ST_OVR] = ovr_q;
      status[`SAP_ST_FRM] = frm_q;
   end
   // reads: status and data differ from what writes reach
   reg [7:0] rd_mux;
   always @* begin
      if (rs_s == `SAP_RS_DATA) begin
         rd_mux = rx_hold_q;
      end else if (rs_s == `SAP_RS_STAT) begin
         rd_mux = status;
      end else if (rs_s == `SAP_RS_CMD) begin
         rd_mux = cmd_q;
      end else begin
         rd_mux = ctl_q;
      end
   end

   // modem changes interrupt only while terminal ready is on
   wire irq_cond = ~cmd_q[`SAP_CMD_RXIRQ_N] & cmd_q[`SAP_CMD_DTR] &
      (rdrf_q | (dsr_q != dsr_s) | (dcd_q != dcd_s));

   // host bus side
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         phi2_q <= 1'b0;
         cmd_q <= `SAP_BYTE_ZERO;
         ctl_q <= `SAP_BYTE_ZERO;
         tx_hold_q <= `SAP_BYTE_ZERO;
         tdre_q <= 1'b1;
         rd_pend_q <= 1'b0;
         rd_rs_q <= `SAP_RS_DATA;
         HOST_DATA_OUT <= `SAP_BYTE_ZERO;
         HOST_DATA_OE_N <= 1'b1;
         irq_q <= 1'b0;
         dsr_q <= 1'b0;
         dcd_q <= 1'b0;
         IRQ_OUT <= 1'b0;
         IRQ_OE_N <= 1'b1;
         DTR_N <= 1'b1;
      end else begin
         phi2_q <= phi2_s;
         // read data held until the phase clock falls
         if (rd_stb) begin
            HOST_DATA_OUT <= rd_mux;
            HOST_DATA_OE_N <= 1'b0;
            rd_pend_q <= 1'b1;
            rd_rs_q <= rs_s;
         end else if (phi2_fall) begin
            HOST_DATA_OE_N <= 1'b1;
            rd_pend_q <= 1'b0;
         end
         if (soft_rst) begin
            // soft reset keeps the upper command bits
            cmd_q <= {cmd_q[7:5], `SAP_CMD_SOFT};
         end else if (wr_stb && rs_s == `SAP_RS_CMD) begin
            cmd_q <= din_s;
         end
         if (wr_stb && rs_s == `SAP_RS_CTL) begin
            ctl_q <= din_s;
         end
         // new write wins over the shifter taking the byte
         if (wr_stb && rs_s == `SAP_RS_DATA) begin
            tx_hold_q <= din_s;
            tdre_q <= 1'b0;
         end else if (soft_rst || (tx_st_q == TX_IDLE && !tdre_q)) begin
            tdre_q <= 1'b1;
         end
         // set wins over clear on status read
         if (irq_cond) begin
            irq_q <= 1'b1;
         end else if (rd_stat_done || soft_rst) begin
            irq_q <= 1'b0;
         end
         if (rd_stat_done) begin
            dsr_q <= dsr_s;
            dcd_q <= dcd_s;
         end
         IRQ_OUT <= 1'b0;
         IRQ_OE_N <= ~(irq_q | irq_cond);
         DTR_N <= ~cmd_q[`SAP_CMD_DTR];
      end
   end

   // receive side, timed by rising edges of the external 16x clock
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rxc_q <= 1'b1;
         rx_st_q <= RX_IDLE;
         rx_ph_q <= 4'h0;
         rx_bit_q <= 4'h0;
         rx_sh_q <= `SAP_BYTE_ZERO;
         rx_hold_q <= `SAP_BYTE_ZERO;
         rdrf_q <= 1'b0;
         ovr_q <= 1'b0;
         frm_q <= 1'b0;
      end else begin
         rxc_q <= rxc_s;
         if (soft_rst) begin
            rx_st_q <= RX_IDLE;
            rdrf_q <= 1'b0;
            ovr_q <= 1'b0;
         end else begin
            if (ff_pop) begin
               rx_hold_q <= ff_out;
               rdrf_q <= 1'b1;
            end else if (rd_data_done) begin
               rdrf_q <= 1'b0;
            end
            if (rx_byte_done) begin
               frm_q <= ~rxd_s;
               ovr_q <= ~ff_in_ready; // fifo full drops the byte
            end
            if (rxc_rise) begin
               rx_ph_q <= rx_ph_q + 4'h1;
               case (rx_st_q)
                  RX_IDLE: begin
                     rx_ph_q <= 4'h0;
                     if (!rxd_s) begin
                        rx_st_q <= RX_START;
                     end
                  end
                  RX_START: begin
                     if (rx_ph_q == `SAP_OVS_MID) begin
                        // false start bit guard
                        rx_st_q <= rxd_s ? RX_IDLE : RX_DATA;
                        rx_ph_q <= 4'h0;
                        rx_bit_q <= 4'h0;
                     end
                  end
                  RX_DATA: begin
                     if (rx_ph_q == `SAP_OVS) begin
                        rx_sh_q <= {rxd_s, rx_sh_q[7:1]};
                        rx_bit_q <= rx_bit_q + 4'h1;
                        if (rx_bit_q == `SAP_BITS - 4'h1) begin
                           rx_st_q <= RX_STOP;
                        end
                     end
                  end
                  default: begin
                     if (rx_ph_q == `SAP_OVS) begin
                        rx_st_q <= RX_IDLE;
                     end
                  end
               endcase
            end
         end
      end
   end

   // transmit side, also paced by the 16x clock
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         tx_st_q <= TX_IDLE;
         tx_ph_q <= 4'h0;
         tx_bit_q <= 4'h0;
         tx_sh_q <= `SAP_BYTE_ZERO;
         SERIAL_OUT <= 1'b1;
      end else if (soft_rst) begin
         tx_st_q <= TX_IDLE;
         SERIAL_OUT <= 1'b1;
      end else begin
         case (tx_st_q)
            TX_IDLE: begin
               tx_ph_q <= 4'h0;
               tx_bit_q <= 4'h0;
               if (!tdre_q) begin
                  tx_sh_q <= tx_hold_q;
                  tx_st_q <= TX_START;
                  SERIAL_OUT <= 1'b0;
               end
            end
            TX_START: begin
               if (rxc_rise) begin
                  tx_ph_q <= tx_ph_q + 4'h1;
                  if (tx_ph_q == `SAP_OVS) begin
                     tx_st_q <= TX_DATA;
                     SERIAL_OUT <= tx_sh_q[0];
                  end
               end
            end
            TX_DATA: begin
               if (rxc_rise) begin
                  tx_ph_q <= tx_ph_q + 4'h1;
                  if (tx_ph_q == `SAP_OVS) begin
                     tx_sh_q <= {1'b0, tx_sh_q[7:1]};
                     tx_bit_q <= tx_bit_q + 4'h1;
                     if (tx_bit_q == `SAP_BITS - 4'h1) begin
                        tx_st_q <= TX_STOP;
                        SERIAL_OUT <= 1'b1;
                     end else begin
                        SERIAL_OUT <= tx_sh_q[1];
                     end
                  end
               end
            end
            default: begin
               if (rxc_rise) begin
                  tx_ph_q <= tx_ph_q + 4'h1;
                  if (tx_ph_q == `SAP_OVS) begin
                     tx_st_q <= TX_IDLE;
                  end
               end
            end
         endcase
      end
   end
endmodule // sap_host_port

// file: design/sap_defs.vh
// Purpose: shared constants for the serial adapter host port
// Assumes: 10 MHz REF_CLK, bus phase clock sampled as a pin
// Notes: register select codes and status bit positions
`ifndef SAP_DEFS_VH
`define SAP_DEFS_VH
`define SAP_RS_DATA 2'b00
`define SAP_RS_STAT 2'b01
`define SAP_RS_CMD 2'b10
`define SAP_RS_CTL 2'b11
`define SAP_BYTE_ZERO 8'h00
`define SAP_ST_IRQ 7
`define SAP_ST_DSR 6
`define SAP_ST_DCD 5
`define SAP_ST_TDRE 4
`define SAP_ST_RDRF 3
`define SAP_ST_OVR 2
`define SAP_ST_FRM 1
`define SAP_ST_PAR 0
`define SAP_CMD_DTR 0
`define SAP_CMD_RXIRQ_N 1
`define SAP_CTL_RXSRC 4
`define SAP_OVS 4'hF
`define SAP_OVS_MID 4'h7
`define SAP_BITS 4'h8
`define SAP_FIFO_W 8
`define SAP_FIFO_D 8
`define SAP_FIFO_AW 3
`define SAP_SYNC_CTL_IDLE 10'h0C8
`define SAP_CMD_SOFT 5'h02
`endif

// file: design/sap_fifo.v
// Purpose: small synchronous fifo with valid and ready on both sides
// Assumes: single clock, async active low reset
// Notes: width and depth are parameters; depth a power of two
`timescale 1ns/1ps
module sap_fifo #(
   parameter W = 8,
   parameter D = 8,
   parameter AW = 3
) (
   input wire clk,
   input wire rst_n,
   input wire clr,
   input wire [W-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   output wire [W-1:0] out_data,
   output wire out_valid,
   input wire out_ready
);
   reg [W-1:0] mem [0:D-1];
   reg [AW:0] wp_q;
   reg [AW:0] rp_q;
   wire full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
   wire empty = (wp_q == rp_q);
   assign in_ready = ~full;
   assign out_valid = ~empty;
   assign out_data = mem[rp_q[AW-1:0]];
   always @(posedge clk) begin
      if (in_valid && !full) begin
         mem[wp_q[AW-1:0]] <= in_data;
      end
   end
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q <= {(AW+1){1'b0}};
         rp_q <= {(AW+1){1'b0}};
      end else if (clr) begin
         wp_q <= {(AW+1){1'b0}};
         rp_q <= {(AW+1){1'b0}};
      end else begin
         if (in_valid && !full) begin
            wp_q <= wp_q + 1'b1;
         end
         if (out_ready && !empty) begin
            rp_q <= rp_q + 1'b1;
         end
      end
   end
endmodule // sap_fifo

// file: design/sap_sync.v
// Purpose: two flip-flop synchroniser for a bus of pin inputs
// Assumes: inputs asynchronous to clk
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module sap_sync #(
   parameter W = 1,
   parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
   input wire clk,
   input wire rst_n,
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] meta_q;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule // sap_sync

// file: tb/sap_host_port_props.sv
// Purpose: port level checks for the serial adapter host port
// Assumes: bus phase clock held high 5 REF_CLK periods and low at least 9
// Notes: bound onto every sap_host_port instance
`timescale 1ns/1ps
module sap_host_port_props (
   input wire REF_CLK,
   input wire RST_N,
   input wire PHI2,
   input wire READ_NOT_WRITE,
   input wire SELECT_ACTIVE_HIGH,
   input wire SELECT_ACTIVE_LOW_N,
   input wire REG_SELECT_LOW,
   input wire REG_SELECT_HIGH,
   input wire [7:0] HOST_DATA_IN,
   input wire HOST_DATA_OE_N,
   input wire IRQ_OUT,
   input wire IRQ_OE_N,
   input wire DTR_N
);
   wire sel = SELECT_ACTIVE_HIGH && !SELECT_ACTIVE_LOW_N;
   wire [1:0] rs = {REG_SELECT_HIGH, REG_SELECT_LOW};
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   AST_RESET_IDLE: assert property ($rose(RST_N) |-> HOST_DATA_OE_N && IRQ_OE_N && DTR_N)
      else $error("outputs not idle after reset");
   AST_IRQ_NEVER_HIGH: assert property (IRQ_OUT == 1'b0)
      else $error("interrupt output driven high");
   AST_OE_CAUSE: assert property ($fell(HOST_DATA_OE_N) |-> $past(PHI2, 2) && $past(READ_NOT_WRITE, 2))
      else $error("data drive without read phase");
   AST_OE_SELECTED: assert property (!HOST_DATA_OE_N |-> $past(sel, 3))
      else $error("data driven while not selected");
   AST_UNSEL_SILENT: assert property (PHI2 && !sel |-> HOST_DATA_OE_N)
      else $error("data driven in unselected cycle");
   AST_READ_ANSWER: assert property ($rose(PHI2) && sel && READ_NOT_WRITE |-> ##[1:4] !HOST_DATA_OE_N)
      else $error("read answer late");
   AST_OE_RELEASE: assert property ($fell(PHI2) |-> ##[1:6] HOST_DATA_OE_N)
      else $error("data lines not released");
   AST_CMD_TO_DTR: assert property ($fell(PHI2) && sel && !READ_NOT_WRITE && rs == 2'b10 |->
      ##[2:5] DTR_N == !HOST_DATA_IN[0])
      else $error("command write not seen on terminal ready");
   AST_SOFT_RESET_DTR: assert property ($fell(PHI2) && sel && !READ_NOT_WRITE && rs == 2'b01 |->
      ##[2:5] DTR_N)
      else $error("soft reset left terminal ready on");
endmodule // sap_host_port_props
bind sap_host_port sap_host_port_props u_props (.REF_CLK(REF_CLK), .RST_N(RST_N), .PHI2(PHI2),
   .READ_NOT_WRITE(READ_NOT_WRITE), .SELECT_ACTIVE_HIGH(SELECT_ACTIVE_HIGH),
   .SELECT_ACTIVE_LOW_N(SELECT_ACTIVE_LOW_N), .REG_SELECT_LOW(REG_SELECT_LOW),
   .REG_SELECT_HIGH(REG_SELECT_HIGH), .HOST_DATA_IN(HOST_DATA_IN), .HOST_DATA_OE_N(HOST_DATA_OE_N),
   .IRQ_OUT(IRQ_OUT), .IRQ_OE_N(IRQ_OE_N), .DTR_N(DTR_N));

// file: tb/sap_bus_master.sv
// Purpose: processor bus master model driving selects and phase clock
// Assumes: one access per phase clock period, 5 cycles high and at least 9 low
// Notes: address and data held at least 6 cycles into the low phase, no hold-time risk
`timescale 1ns/1ps
module sap_bus_master (
   input wire clk,
   input wire [7:0] dout,
   input wire oe_n,
   output reg phi2,
   output reg rw,
   output reg cs_hi,
   output reg cs_lo_n,
   output reg rs_lo,
   output reg rs_hi,
   output reg [7:0] din
);
   initial begin
      phi2 = 1'b0;
      rw = 1'b1;
      cs_hi = 1'b0;
      cs_lo_n = 1'b1;
      {rs_hi, rs_lo} = 2'b00;
      din = 8'h00;
   end
   // sel is {high select, low select}; 2'b10 selects the device
   task acc(input r, input [1:0] rs, input [1:0] sel, input [7:0] wd, output [7:0] rd);
      begin
         @(posedge clk) #1;
         rw = r;
         {rs_hi, rs_lo} = rs;
         {cs_hi, cs_lo_n} = sel;
         din = r ? ~din : wd; // released lines never keep the old value
         repeat (3) @(posedge clk);
         #1 phi2 = 1'b1;
         repeat (5) @(posedge clk);
         rd = (oe_n === 1'b0) ? dout : 8'hXX;
         #1 phi2 = 1'b0;
         repeat (5) @(posedge clk);
      end
   endtask
endmodule // sap_bus_master

// file: tb/tb_sap_host_port.sv
// Purpose: self checking bench for the serial adapter host port
// Assumes: external receive clock runs only inside frames
// Notes: modem inputs held low, matching their reset state, so no modem change interrupt is raised
`timescale 1ns/1ps
module tb_sap_host_port;
   reg REF_CLK = 1'b0;
   reg RST_N = 1'b0;
   reg receive_clock_16x = 1'b1;
   reg rxd = 1'b1;
   reg dsr_n = 1'b0;
   reg dcd_n = 1'b0;
   wire phi2, rw, cs_hi, cs_lo_n, rs_lo, rs_hi, oe_n, irq_out, irq_oe_n, txd, dtr_n;
   wire [7:0] din, dout;
   wire irq_line = irq_oe_n ? 1'b1 : irq_out; // pull-up on shared line
   integer error_cnt = 0;
   integer checks_done = 0;
   integer i;
   reg [31:0] r;
   reg [7:0] rd, c, t, b;
   reg [7:0] exp_q [0:9];
   reg [9:0] txf;
   always #50 REF_CLK = ~REF_CLK;
   sap_bus_master u_bus (.clk(REF_CLK), .dout(dout), .oe_n(oe_n), .phi2(phi2), .rw(rw), .cs_hi(cs_hi),
      .cs_lo_n(cs_lo_n), .rs_lo(rs_lo), .rs_hi(rs_hi), .din(din));
   sap_host_port uut (.REF_CLK(REF_CLK), .RST_N(RST_N), .PHI2(phi2), .READ_NOT_WRITE(rw),
      .SELECT_ACTIVE_HIGH(cs_hi), .SELECT_ACTIVE_LOW_N(cs_lo_n), .REG_SELECT_LOW(rs_lo),
      .REG_SELECT_HIGH(rs_hi), .HOST_DATA_IN(din), .HOST_DATA_OUT(dout), .HOST_DATA_OE_N(oe_n),
      .IRQ_OUT(irq_out), .IRQ_OE_N(irq_oe_n), .RECEIVE_CLOCK_16X(receive_clock_16x), .SERIAL_IN(rxd),
      .DSR_N(dsr_n), .DCD_N(dcd_n), .SERIAL_OUT(txd), .DTR_N(dtr_n));
   task finish_test;
      begin
         $display("errors %0d checks %0d", error_cnt, checks_done);
         if (error_cnt == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   task chk(input [7:0] got, input [7:0] exp, input [7:0] mask);
      begin
         checks_done = checks_done + 1;
         if ((got & mask) !== (exp & mask)) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   function [9:0] frame_of(input [7:0] v);
      frame_of = {1'b1, v, 1'b0}; // stop high, data lsb first, start low
   endfunction
   function [7:0] cmd_after_soft(input [7:0] v);
      cmd_after_soft = {v[7:5], 5'h02};
   endfunction
   task rd_reg(input [1:0] rs, input [7:0] exp, input [7:0] mask);
      begin
         u_bus.acc(1'b1, rs, 2'b10, 8'h00, rd);
         chk(rd, exp, mask);
      end
   endtask
   task wr_reg(input [1:0] rs, input [7:0] d, input [1:0] sel);
      u_bus.acc(1'b0, rs, sel, d, rd);
   endtask
   // start, 8 data lsb first, stop; 16 clock periods of 4 cycles a bit
   task send(input [7:0] v);
      reg [9:0] f;
      integer k;
      begin
         f = frame_of(v);
         for (k = 0; k < 160; k = k + 1) begin
            @(posedge REF_CLK) #1 receive_clock_16x = 1'b0;
            rxd = f[k / 16];
            if (k % 16 == 7) txf[k / 16] = txd; // mid bit of the transmit frame
            repeat (2) @(posedge REF_CLK);
            #1 receive_clock_16x = 1'b1;
            @(posedge REF_CLK);
         end
      end
   endtask
   initial begin
      repeat (100000) @(posedge REF_CLK);
      error_cnt = error_cnt + 1;
      finish_test;
   end
   initial begin
      r = $urandom(32'h944C4C91);
      repeat (2) @(posedge REF_CLK);
      #1 RST_N = 1'b1;
      repeat (4) @(posedge REF_CLK);
      #1 chk({5'h00, oe_n, irq_line, dtr_n}, 8'h07, 8'hFF);
      rd_reg(2'b10, 8'h00, 8'hFF);
      rd_reg(2'b11, 8'h00, 8'hFF);
      for (i = 0; i < 4; i = i + 1) begin
         r = $urandom;
         c = r[7:0];
         t = r[15:8];
         wr_reg(2'b10, c, 2'b10);
         wr_reg(2'b11, t, 2'b10);
         wr_reg(2'b10, ~c, 2'b00); // unselected, high select low
         wr_reg(2'b11, ~t, 2'b11); // unselected, low select high
         wr_reg(2'b00, r[23:16] | 8'h01, 2'b10);
         rd_reg(2'b10, c, 8'hFF);
         rd_reg(2'b11, t, 8'hFF);
         rd_reg(2'b00, 8'h00, 8'hFF);
         // idle shifter takes the first byte at once, later ones wait for the 16x clock
         rd_reg(2'b01, (i == 0) ? 8'h10 : 8'h00, 8'h10);
      end
      wr_reg(2'b01, r[31:24], 2'b10);
      rd_reg(2'b10, cmd_after_soft(c), 8'hFF);
      rd_reg(2'b11, t, 8'hFF);
      wr_reg(2'b10, 8'h01, 2'b10);
      r = $urandom;
      b = r[7:0];
      t = r[15:8];
      wr_reg(2'b00, t, 2'b10);
      send(b);
      chk(txf[8:1], t, 8'hFF);
      chk({6'h00, txf[9], txf[0]}, 8'h02, 8'hFF);
      repeat (10) @(posedge REF_CLK);
      #1 chk({7'h00, irq_line}, 8'h00, 8'h01);
      rd_reg(2'b01, 8'h88, 8'hE8);
      rd_reg(2'b00, b, 8'hFF);
      rd_reg(2'b01, 8'h00, 8'h08);
      #1 chk({7'h00, irq_line}, 8'h01, 8'h01);
      for (i = 0; i < 10; i = i + 1) begin
         r = $urandom;
         exp_q[i] = r[7:0];
         send(exp_q[i]);
      end
      repeat (10) @(posedge REF_CLK);
      rd_reg(2'b01, 8'h0C, 8'h0C);
      // holding register plus eight fifo words; the tenth byte overran
      for (i = 0; i < 9; i = i + 1)
         rd_reg(2'b00, exp_q[i], 8'hFF);
      for (i = 0; i < 2; i = i + 1)
         u_bus.acc(1'b1, 2'b00, 2'b10, 8'h00, rd);
      rd_reg(2'b01, 8'h00, 8'h08);
      finish_test;
   end
endmodule // tb_sap_host_port
